// ### hw/sbcie_irq_enable_flags.sv
// interrupt enable register, interrupt flag register and interrupt pin control
// Behaviour
// - frame address bits 15..14 equal 01 select the interrupt enable register
// - readback select 1 returns flags, 0 returns enable feedback
// - no-write flag 1 only reads; 0 also writes payload into enable register
// - standby watchdog overflow: interrupt if enabled, reset request otherwise
// - watchdog timeout enable self-clears on every overflow; host re-arms it
// - temperature warning change in either direction raises interrupt when enabled
// - ground offset crossing in either direction raises interrupt when enabled
// - frames without 16 clocks ignored; if enabled, reset in start-up/restart, flagged otherwise
// - any regulator ok bit clearing raises interrupt when enabled
// - any CAN fault status change raises interrupt when enabled
// - any LIN fault status change raises interrupt when enabled
// - wake falling edge: interrupt in normal/flash/standby if enabled, else standby reset
// - local wake works only while the global wake port enable is set
// - watchdog restart while watchdog off raises interrupt when enabled
// - CAN wake: interrupt in standby, or normal/flash unless active; else standby reset
// - LIN wake: interrupt in standby, or normal/flash unless active; else standby reset
// - flag register clears on every read of it and on every reset
// - events arriving during a flag read survive the clear
// - after a flag read the interrupt pin is released for a fixed time
// - slow interrupts reach the pin once per watchdog period in normal mode
// - clock count and battery failures reach the pin immediately except during the post-read release
`timescale 1ns/100ps
module sbcie_irq_enable_flags
  import sbcie_pkg::*;
#(
  parameter int RELEASE_CYCLES = IRQ_RELEASE_CYCLES
) (
  input  wire logic               sys_clk,         // system clock, 10 MHz
  input  wire logic               reset,           // synchronous reset, high
  input  wire logic               frameStrobe,     // one-cycle pulse: a frame ended
  input  wire logic [FRAME_W-1:0] frameWord,       // received frame word
  input  wire logic [CLK_COUNT_W-1:0] frameClkCount, // clock edges counted in the frame
  output logic      [FRAME_W-1:0] answerWord,      // returned register word
  output logic                    answerValid,     // one-cycle pulse: answer updated
  input  wire sbcie_mode_t        opMode,          // current operating mode
  input  wire logic               wdOverflow,      // watchdog overflow pulse
  input  wire logic               wdRestartOff,    // watchdog restart during watchdog off pulse
  input  wire logic               wdPeriodTick,    // start of watchdog period pulse
  input  wire logic               tempWarn,        // temperature above warning limit
  input  wire logic               groundShiftOut,  // ground offset beyond limit
  input  wire logic [3:0]         canFaultStatus,  // CAN failure diagnosis
  input  wire logic [1:0]         linFaultStatus,  // LIN failure diagnosis
  input  wire logic               mainRegulatorOk, // main regulator ok
  input  wire logic               busRegulatorOk,  // bus regulator ok
  input  wire logic               switchSupplyOk,  // switch supply ok
  input  wire logic               wakePin,         // local wake input level
  input  wire logic               wakePortEnable,  // global wake port enable
  input  wire logic               canWakeEvent,    // CAN bus wake event pulse
  input  wire logic               canActive,       // CAN already active
  input  wire logic               linWakeEvent,    // LIN bus wake event pulse
  input  wire logic               linActive,       // LIN already active
  input  wire logic               batteryFail,     // battery failure pulse
  output logic                    irqOutN,         // interrupt pin, low active
  output logic                    resetRequest     // one-cycle reset request
);
  sbcie_gate_if gif ();

  logic [PAYLOAD_W-1:0] enable_r, enable_nxt;
  logic [PAYLOAD_W-1:0] flags_r, flags_nxt;
  logic [FRAME_W-1:0]   answer_r, answer_nxt;
  logic                 answerValid_r, answerValid_nxt;
  logic                 resetReq_r, resetReq_nxt;
  logic                 batPend_r, batPend_nxt;
  logic                 primed_r, primed_nxt;
  sbcie_status_t        prev_r, prev_nxt, statNow;
  logic [PAYLOAD_W-1:0] evt;
  logic                 addrHit, countOk, accessOk, countFail;
  logic                 readbackSelect, noWriteFlag, flagRead;
  logic                 inStandby, inNormFlash, inStartRestart, wakeFall;

  // --------------------------------------------------------------------------
  // frame decode
  // --------------------------------------------------------------------------
  always_comb begin
    addrHit        = (frameWord[ADDR_HI:ADDR_LO] == ADDR_IRQ_ENABLE);
    countOk        = (frameClkCount == CLK_COUNT_OK);
    accessOk       = frameStrobe && countOk && addrHit;
    countFail      = frameStrobe && !countOk;
    readbackSelect = frameWord[RRS_BIT];
    noWriteFlag    = frameWord[NOWRITE_BIT];
    flagRead       = accessOk && readbackSelect;
    inStandby      = (opMode == MODE_STANDBY);
    inNormFlash    = (opMode == MODE_NORMAL) || (opMode == MODE_FLASH);
    inStartRestart = (opMode == MODE_STARTUP) || (opMode == MODE_RESTART);
  end

  // --------------------------------------------------------------------------
  // event detection
  // --------------------------------------------------------------------------
  // change detectors stay quiet until one clean sample after reset exists
  always_comb begin
    statNow = '{temp: tempWarn, ground: groundShiftOut, can: canFaultStatus, lin: linFaultStatus,
                supplyOk: {mainRegulatorOk, busRegulatorOk, switchSupplyOk}, wake: wakePin};
    prev_nxt     = statNow;
    primed_nxt   = 1'b1;
    evt          = '0;
    resetReq_nxt = 1'b0;
    wakeFall     = primed_r && prev_r.wake && !statNow.wake && wakePortEnable;
    if (wdOverflow && inStandby) begin
      if (enable_r[BIT_WDT_TIMEOUT]) begin
        evt[BIT_WDT_TIMEOUT] = 1'b1;
      end else begin
        resetReq_nxt = 1'b1;
      end
    end
    if (primed_r) begin
      evt[BIT_OVERTEMP]   = enable_r[BIT_OVERTEMP] && (statNow.temp != prev_r.temp);
      evt[BIT_GND_OFFSET] = enable_r[BIT_GND_OFFSET] && (statNow.ground != prev_r.ground);
      evt[BIT_SUPPLY]     = enable_r[BIT_SUPPLY] && |(prev_r.supplyOk & ~statNow.supplyOk);
      evt[BIT_CAN_FAULT]  = enable_r[BIT_CAN_FAULT] && (statNow.can != prev_r.can);
      evt[BIT_LIN_FAULT]  = enable_r[BIT_LIN_FAULT] && (statNow.lin != prev_r.lin);
    end
    if (countFail && enable_r[BIT_CLK_COUNT]) begin
      if (inStartRestart) begin
        resetReq_nxt = 1'b1;
      end else begin
        evt[BIT_CLK_COUNT] = 1'b1;
      end
    end
    if (wakeFall) begin
      if (enable_r[BIT_LOCAL_WAKE]) begin
        evt[BIT_LOCAL_WAKE] = inNormFlash || inStandby;
      end else if (inStandby) begin
        resetReq_nxt = 1'b1;
      end
    end
    evt[BIT_WDT_RESTART] = wdRestartOff && enable_r[BIT_WDT_RESTART];
    if (canWakeEvent) begin
      if (enable_r[BIT_CAN_WAKE]) begin
        evt[BIT_CAN_WAKE] = inStandby || (inNormFlash && !canActive);
      end else if (inStandby) begin
        resetReq_nxt = 1'b1;
      end
    end
    if (linWakeEvent) begin
      if (enable_r[BIT_LIN_WAKE]) begin
        evt[BIT_LIN_WAKE] = inStandby || (inNormFlash && !linActive);
      end else if (inStandby) begin
        resetReq_nxt = 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // registers: enable, flags, answer
  // --------------------------------------------------------------------------
  always_comb begin
    enable_nxt = enable_r;
    if (accessOk && !noWriteFlag) begin
      // reserved bit is masked so a careless host cannot arm it
      enable_nxt = frameWord[PAYLOAD_W-1:0] & ENABLE_MASK;
    end
    // overflow wins over a write landing in the same cycle: fail-safe side
    if (wdOverflow) begin
      enable_nxt[BIT_WDT_TIMEOUT] = 1'b0;
    end
    flags_nxt   = (flagRead ? FLAGS_RESET : flags_r) | evt;
    batPend_nxt = (flagRead ? 1'b0 : batPend_r) | batteryFail;
    answer_nxt  = answer_r;
    if (accessOk) begin
      answer_nxt = {frameWord[FRAME_W-1:HDR_LO], readbackSelect ? flags_r : enable_r};
    end
    answerValid_nxt = accessOk;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      enable_r      <= ENABLE_RESET;
      flags_r       <= FLAGS_RESET;
      batPend_r     <= 1'b0;
      answer_r      <= '0;
      answerValid_r <= 1'b0;
      resetReq_r    <= 1'b0;
      prev_r        <= STATUS_RESET;
      primed_r      <= 1'b0;
    end else begin
      enable_r      <= enable_nxt;
      flags_r       <= flags_nxt;
      batPend_r     <= batPend_nxt;
      answer_r      <= answer_nxt;
      answerValid_r <= answerValid_nxt;
      resetReq_r    <= resetReq_nxt;
      prev_r        <= prev_nxt;
      primed_r      <= primed_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // pin gate
  // --------------------------------------------------------------------------
  assign gif.criticalPend = flags_r[BIT_CLK_COUNT] || batPend_r;
  assign gif.normalPend   = |(flags_r & ~(PAYLOAD_W'(1) << BIT_CLK_COUNT));
  assign gif.flagRead     = flagRead;
  assign gif.periodTick   = wdPeriodTick;
  assign gif.normalMode   = (opMode == MODE_NORMAL);

  sbcie_irq_gate #(
    .RELEASE_CYCLES (RELEASE_CYCLES)
  ) u_gate (
    .sys_clk (sys_clk),
    .reset   (reset),
    .gif     (gif.gate)
  );

  assign irqOutN      = !gif.irqAsserted;
  assign answerWord   = answer_r;
  assign answerValid  = answerValid_r;
  assign resetRequest = resetReq_r;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence s_goodWrite;
    accessOk && !noWriteFlag && !wdOverflow;
  endsequence
  sequence s_flagReadQuiet;
    flagRead && evt == '0;
  endsequence

  property p_ignore_bad;
    countFail && !wdOverflow |=> $stable(enable_r);
  endproperty
  a_ignore_bad: assert property (p_ignore_bad) else $error("bad clock count frame changed enables");

  property p_write;
    s_goodWrite |=> enable_r == ($past(frameWord[PAYLOAD_W-1:0]) & ENABLE_MASK);
  endproperty
  a_write: assert property (p_write) else $error("enable write not stored");

  property p_read_only;
    accessOk && noWriteFlag && !wdOverflow |=> $stable(enable_r);
  endproperty
  a_read_only: assert property (p_read_only) else $error("read-only frame altered enables");

  property p_readback;
    accessOk |=> answerValid && answerWord[PAYLOAD_W-1:0] ==
                 ($past(readbackSelect) ? $past(flags_r) : $past(enable_r));
  endproperty
  a_readback: assert property (p_readback) else $error("wrong register returned");

  property p_wdt_clear;
    wdOverflow |=> !enable_r[BIT_WDT_TIMEOUT];
  endproperty
  a_wdt_clear: assert property (p_wdt_clear) else $error("timeout enable not cleared");

  property p_wdt_reset;
    wdOverflow && inStandby && !enable_r[BIT_WDT_TIMEOUT] |=> resetRequest && !flags_r[BIT_WDT_TIMEOUT];
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("overflow without enable gave no reset");

  property p_read_clear;
    s_flagReadQuiet |=> flags_r == FLAGS_RESET;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("flags not cleared by read");

  property p_keep_event;
    flagRead && wdRestartOff && enable_r[BIT_WDT_RESTART] |=> flags_r[BIT_WDT_RESTART];
  endproperty
  a_keep_event: assert property (p_keep_event) else $error("event lost during flag read");

  property p_can_wake_active;
    canWakeEvent && inNormFlash && canActive && !flags_r[BIT_CAN_WAKE] && !flagRead |=> !flags_r[BIT_CAN_WAKE];
  endproperty
  a_can_wake_active: assert property (p_can_wake_active) else $error("CAN wake flagged while active");

  property p_wake_gate;
    !wakePortEnable |-> !evt[BIT_LOCAL_WAKE];
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake flagged with port disabled");
endmodule : sbcie_irq_enable_flags

// ### hw/sbcie_irq_gate.sv
// interrupt pin gate: rate limit and post-read release
`timescale 1ns/100ps
module sbcie_irq_gate
  import sbcie_pkg::*;
#(
  parameter int RELEASE_CYCLES = IRQ_RELEASE_CYCLES
) (
  input wire logic  sys_clk,  // system clock
  input wire logic  reset,    // synchronous reset, high
  sbcie_gate_if.gate gif      // pending and read info
);
  localparam int CNT_W = $clog2(RELEASE_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(RELEASE_CYCLES - 1);

  sbcie_gate_t      state_r, state_nxt;
  logic [CNT_W-1:0] holdCnt_r, holdCnt_nxt;
  logic             token_r, token_nxt;
  logic             want;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    state_nxt   = state_r;
    holdCnt_nxt = holdCnt_r;
    token_nxt   = token_r;
    // outside normal mode the slow group is not throttled
    want = gif.criticalPend || (gif.normalPend && (!gif.normalMode || token_r));
    case (state_r)
      GATE_IDLE: begin
        if (want) begin
          state_nxt = GATE_LOW;
          if (!gif.criticalPend && gif.normalMode) begin
            token_nxt = 1'b0;
          end
        end
      end
      GATE_LOW: begin
        if (gif.flagRead) begin
          state_nxt   = GATE_HOLD;
          holdCnt_nxt = CNT_LOAD;
        end else if (!(gif.criticalPend || gif.normalPend)) begin
          state_nxt = GATE_IDLE;
        end
      end
      GATE_HOLD: begin
        if (gif.flagRead) begin
          holdCnt_nxt = CNT_LOAD;
        end else if (holdCnt_r == '0) begin
          state_nxt = GATE_IDLE;
        end else begin
          holdCnt_nxt = holdCnt_r - CNT_W'(1);
        end
      end
      default: state_nxt = GATE_IDLE;
    endcase
    // a new period re-arms the token even if it was spent this cycle
    if (gif.periodTick) begin
      token_nxt = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r   <= GATE_IDLE;
      holdCnt_r <= '0;
      token_r   <= 1'b1;
    end else begin
      state_r   <= state_nxt;
      holdCnt_r <= holdCnt_nxt;
      token_r   <= token_nxt;
    end
  end

  assign gif.irqAsserted = (state_r == GATE_LOW);

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  property p_release;
    gif.irqAsserted && gif.flagRead |=> !gif.irqAsserted && holdCnt_r == CNT_LOAD;
  endproperty
  a_release: assert property (p_release) else $error("pin not released after flag read");

  property p_critical;
    state_r == GATE_IDLE && gif.criticalPend |=> gif.irqAsserted;
  endproperty
  a_critical: assert property (p_critical) else $error("critical interrupt delayed");

  property p_throttle;
    state_r == GATE_IDLE && !token_r && !gif.criticalPend && gif.normalMode |=> !gif.irqAsserted;
  endproperty
  a_throttle: assert property (p_throttle) else $error("slow interrupt signalled twice in period");
endmodule : sbcie_irq_gate

// ### include/sbcie_gate_if.sv
// link between flag logic and interrupt pin gate
`timescale 1ns/100ps
interface sbcie_gate_if;
  logic criticalPend;
  logic normalPend;
  logic flagRead;
  logic periodTick;
  logic normalMode;
  logic irqAsserted;
  modport ctrl (output criticalPend, output normalPend, output flagRead, output periodTick,
                output normalMode, input irqAsserted);
  modport gate (input criticalPend, input normalPend, input flagRead, input periodTick,
                input normalMode, output irqAsserted);
endinterface : sbcie_gate_if

// ### include/sbcie_pkg.sv
// constants and types for the interrupt enable and flag block
package sbcie_pkg;
  // --------------------------------------------------------------------------
  // frame layout
  // --------------------------------------------------------------------------
  localparam int         FRAME_W         = 16;
  localparam int         PAYLOAD_W       = 12;
  localparam int         ADDR_HI         = 15;
  localparam int         ADDR_LO         = 14;
  localparam int         RRS_BIT         = 13;
  localparam int         NOWRITE_BIT     = 12;
  localparam int         HDR_LO          = 12;
  localparam logic [1:0] ADDR_IRQ_ENABLE = 2'h1;
  localparam int         CLK_COUNT_W     = 6;
  localparam logic [5:0] CLK_COUNT_OK    = 6'h10;
  // --------------------------------------------------------------------------
  // enable and flag bit positions (same positions in both registers)
  // --------------------------------------------------------------------------
  localparam int BIT_WDT_TIMEOUT = 11;
  localparam int BIT_OVERTEMP    = 10;
  localparam int BIT_GND_OFFSET  = 9;
  localparam int BIT_CLK_COUNT   = 8;
  localparam int BIT_RESERVED    = 7;
  localparam int BIT_SUPPLY      = 6;
  localparam int BIT_CAN_FAULT   = 5;
  localparam int BIT_LIN_FAULT   = 4;
  localparam int BIT_LOCAL_WAKE  = 3;
  localparam int BIT_WDT_RESTART = 2;
  localparam int BIT_CAN_WAKE    = 1;
  localparam int BIT_LIN_WAKE    = 0;
  localparam logic [11:0] ENABLE_RESET = 12'h000;
  localparam logic [11:0] ENABLE_MASK  = 12'hf7f;
  localparam logic [11:0] FLAGS_RESET  = 12'h000;
  // --------------------------------------------------------------------------
  // timing
  // --------------------------------------------------------------------------
  localparam int SYS_CLK_PERIOD_NS   = 100;
  localparam int IRQ_RELEASE_TIME_NS = 1000;
  localparam int IRQ_RELEASE_CYCLES  = (IRQ_RELEASE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS < 1 ? 1 :
                                       (IRQ_RELEASE_TIME_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  // --------------------------------------------------------------------------
  // types
  // --------------------------------------------------------------------------
  typedef enum logic [5:0] {
    MODE_STARTUP = 6'h01, MODE_RESTART = 6'h02, MODE_NORMAL = 6'h04,
    MODE_FLASH   = 6'h08, MODE_STANDBY = 6'h10, MODE_SLEEP  = 6'h20
  } sbcie_mode_t;
  typedef enum logic [2:0] {GATE_IDLE = 3'h1, GATE_LOW = 3'h2, GATE_HOLD = 3'h4} sbcie_gate_t;
  typedef struct packed {
    logic       temp;
    logic       ground;
    logic [3:0] can;
    logic [1:0] lin;
    logic [2:0] supplyOk;
    logic       wake;
  } sbcie_status_t;
  localparam sbcie_status_t STATUS_RESET = '{temp: 1'b0, ground: 1'b0, can: 4'h0, lin: 2'h0,
                                             supplyOk: 3'h7, wake: 1'b1};
endpackage : sbcie_pkg

// ### tb/sbcie_host_model.sv
// host side model that issues one register frame at a time
`timescale 1ns/100ps
module sbcie_host_model
  import sbcie_pkg::*;
(
  input  wire logic               sys_clk,      // system clock
  output logic                    frameStrobe,  // frame end pulse
  output logic [FRAME_W-1:0]      frameWord,    // frame word
  output logic [CLK_COUNT_W-1:0]  frameClkCount // clocks seen in frame
);
  initial begin
    frameStrobe = 1'b0;
    frameWord = 16'h0000;
    frameClkCount = 6'h00;
  end
  task automatic send(input logic [FRAME_W-1:0] w, input logic [CLK_COUNT_W-1:0] n);
    @(negedge sys_clk);
    frameStrobe = 1'b1;
    frameWord = {w[15:8], 1'b0, w[6:0]};
    frameClkCount = n;
    @(negedge sys_clk);
    frameStrobe = 1'b0;
    // stale word inverted so a late sample never looks like a real frame
    frameWord = ~frameWord;
    frameClkCount = ~n;
  endtask : send
endmodule : sbcie_host_model

// ### tb/sbcie_irq_enable_flags_tb_top.sv
// self-checking bench for the interrupt enable and flag block
`timescale 1ns/100ps
module sbcie_irq_enable_flags_tb_top
  import sbcie_pkg::*;
;
  logic        frameStrobe, answerValid, irqOutN, resetRequest;
  logic [15:0] frameWord, answerWord;
  logic [5:0]  frameClkCount;
  logic [5:0]  pls = 6'h00;
  logic        av, rq;
  logic        canActive = 1'b0, linActive = 1'b0, busRegulatorOk = 1'b1, switchSupplyOk = 1'b1;
  logic        sys_clk = 1'b0, reset = 1'b1, tempWarn = 1'b0, groundShiftOut = 1'b0;
  logic        mainRegulatorOk = 1'b1, wakePin = 1'b1, wakePortEnable = 1'b1;
  logic [3:0]  canFaultStatus = 4'h0;
  logic [1:0]  linFaultStatus = 2'h0;
  sbcie_mode_t opMode = MODE_STANDBY;
  logic [31:0] rnd = 32'h0000002c;
  logic [11:0] en = 12'h000;
  int          miscompares = 0, num_checks = 0, cyc = 0;
  // pulses: 0 overflow, 1 restart, 2 period tick, 3 can wake, 4 lin wake, 5 battery
  sbcie_irq_enable_flags #(.RELEASE_CYCLES(2)) i_dut (
    .sys_clk, .reset, .frameStrobe, .frameWord, .frameClkCount, .answerWord, .answerValid, .opMode,
    .wdOverflow(pls[0]), .wdRestartOff(pls[1]), .wdPeriodTick(pls[2]), .tempWarn, .groundShiftOut,
    .canFaultStatus, .linFaultStatus, .mainRegulatorOk, .busRegulatorOk, .switchSupplyOk,
    .wakePin, .wakePortEnable, .canWakeEvent(pls[3]), .canActive, .linWakeEvent(pls[4]),
    .linActive, .batteryFail(pls[5]), .irqOutN, .resetRequest
  );
  sbcie_host_model i_host (.sys_clk, .frameStrobe, .frameWord, .frameClkCount);
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end
  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  task automatic chk_word(input string nm, input logic [15:0] e, input logic [15:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask : chk_word
  task automatic chk_bit(input string nm, input logic e, input logic s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %b seen %b", nm, e, s);
    end
  endtask : chk_bit
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : wt
  // ends at the falling edge after the answer cycle
  task automatic frm(input logic [15:0] w, input logic [5:0] n = 6'h10);
    i_host.send(w, n);
    // answer and reset request pulses stand only in the cycle after the strobe
    av = answerValid;
    rq = resetRequest;
    wt(1);
  endtask : frm
  task automatic rdf(input logic [11:0] e);
    frm(16'h7000);
    chk_word("flags", {4'h7, e}, answerWord);
    chk_bit("irq released", 1'b1, irqOutN);
  endtask : rdf
  task automatic rdfb(input logic [11:0] e);
    frm(16'h5000);
    chk_bit("answer valid", 1'b1, av);
    chk_word("enable", {4'h5, e}, answerWord);
  endtask : rdfb
  task automatic pulse(input int i);
    pls[i] = 1'b1;
    wt(1);
    rq = resetRequest;
    pls = 6'h00;
    wt(1);
  endtask : pulse
  // ---------------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------------
  initial begin
    wt(2);
    reset = 1'b0;
    wt(2);
    rdfb(12'h000);
    rdf(12'h000);
    for (int k = 0; k < 4; k++) begin
      rnd = xs(rnd);
      frm({4'h4, rnd[11:0] & 12'hf7f});
      chk_word("old enable", {4'h4, en}, answerWord);
      frm({2'h2 + 2'(k % 3), rnd[13:0]});
      chk_bit("no answer", 1'b0, av);
      chk_word("answer kept", {4'h4, en}, answerWord);
      en = rnd[11:0] & 12'hf7f;
      frm({4'h5, ~rnd[11:0]});
      chk_word("read only", {4'h5, en}, answerWord);
    end
    frm(16'h4f7f);
    pulse(1);
    rdf(12'h004);
    tempWarn = 1'b1;
    wt(2);
    rdf(12'h400);
    groundShiftOut = 1'b1;
    wt(2);
    rdf(12'h200);
    canFaultStatus = rnd[3:0] | 4'h1;
    linFaultStatus = 2'h2;
    wt(2);
    rdf(12'h030);
    mainRegulatorOk = 1'b0;
    wt(2);
    rdf(12'h040);
    mainRegulatorOk = 1'b1;
    wakePin = 1'b0;
    wt(2);
    rdf(12'h008);
    wakePortEnable = 1'b0;
    wakePin = 1'b1;
    wt(1);
    wakePin = 1'b0;
    wt(2);
    rdf(12'h000);
    pulse(3);
    rdf(12'h002);
    pulse(4);
    rdf(12'h001);
    frm(16'h5000, 6'h0f);
    chk_bit("ignored", 1'b0, av);
    rdf(12'h100);
    pulse(0);
    chk_bit("no reset", 1'b0, rq);
    rdf(12'h800);
    rdfb(12'h77f);
    pulse(0);
    chk_bit("reset", 1'b1, rq);
    opMode = MODE_STARTUP;
    frm(16'h5000, 6'h11);
    chk_bit("reset", 1'b1, rq);
    opMode = MODE_STANDBY;
    fork
      frm(16'h7000);
      begin
        wt(1);
        tempWarn = 1'b0;
      end
    join
    chk_word("flags", 16'h7000, answerWord);
    rdf(12'h400);
    opMode = MODE_NORMAL;
    pulse(1);
    wt(1);
    chk_bit("irq", 1'b0, irqOutN);
    rdf(12'h004);
    groundShiftOut = 1'b0;
    wt(6);
    chk_bit("irq", 1'b1, irqOutN);
    pulse(2);
    wt(2);
    chk_bit("irq", 1'b0, irqOutN);
    rdf(12'h200);
    wt(3);
    canFaultStatus = 4'h0;
    pulse(5);
    wt(1);
    chk_bit("irq", 1'b0, irqOutN);
    rdf(12'h020);
    wt(3);
    frm(16'h5000, 6'h0f);
    wt(1);
    chk_bit("irq", 1'b0, irqOutN);
    rdf(12'h100);
    // bus wake-ups while the bus is already active must leave no flag
    canActive = 1'b1;
    linActive = 1'b1;
    pulse(3);
    pulse(4);
    switchSupplyOk = 1'b0;
    wt(2);
    rdf(12'h040);
    busRegulatorOk = 1'b0;
    wt(2);
    rdf(12'h040);
    results();
  end
endmodule : sbcie_irq_enable_flags_tb_top
